// [hdl/muldiv_pkg.sv]
package muldiv_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on the internal peripheral bus)
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL_ADDR    = 16'hff68; // control register
    localparam logic [15:0] AL_ADDR      = 16'hff60; // operand a, low half
    localparam logic [15:0] AH_ADDR      = 16'hff62; // operand a, high half
    localparam logic [15:0] B_ADDR       = 16'hff64; // operand b
    localparam logic [15:0] REM_ADDR     = 16'hff66; // remainder result

    // ------------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------------
    localparam int          RUN_BIT_POS  = 7;        // start / run bit
    localparam int          MODE_BIT_POS = 0;        // 1 multiply, 0 divide
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [15:0] DATA_RESET   = 16'h0000;

    // ------------------------------------------------------------------
    // timing counts in internal clocks
    // ------------------------------------------------------------------
    localparam int          MUL_CYCLES   = 16;
    localparam int          DIV_CYCLES   = 32;

endpackage : muldiv_pkg

// [hdl/muldiv_step.sv]
`timescale 1ns/1ns
// one iteration of the shared shift engine: a shift-add multiply step or
// a restoring divide step, chosen by mode_mul_i
module muldiv_step
(
    input  wire logic        mode_mul_i,   // 1 multiply step, 0 divide step
    input  wire logic [31:0] acc_a_i,      // operand a / partial result
    input  wire logic [15:0] acc_r_i,      // partial remainder
    input  wire logic [15:0] divisor_i,    // operand b
    output logic      [31:0] acc_a_o,      // next operand a value
    output logic      [15:0] acc_r_o       // next remainder value
);

    logic [16:0] sum;                      // multiply partial sum with carry
    logic [16:0] trial;                    // shifted remainder before compare
    logic [16:0] diff;                     // trial minus divisor

    // ------------------------------------------------------------------
    // combinational step
    // ------------------------------------------------------------------
    always_comb
    begin
        sum     = {1'b0, acc_a_i[31:16]};
        trial   = {acc_r_i, acc_a_i[31]};
        diff    = trial - {1'b0, divisor_i};
        acc_a_o = acc_a_i;
        acc_r_o = acc_r_i;
        if (mode_mul_i)
        begin
            // high half accumulates b when the low bit is set, then the
            // whole word moves right; the multiplier bits drop out below
            if (acc_a_i[0])
            begin
                sum = {1'b0, acc_a_i[31:16]} + {1'b0, divisor_i};
            end
            acc_a_o = {sum, acc_a_i[15:1]};
            acc_r_o = 16'h0000;
        end
        else
        begin
            // restoring division, quotient bits shift in at the bottom;
            // a 17-bit trial keeps the carry so no remainder bit is lost
            if (!diff[16])
            begin
                acc_a_o = {acc_a_i[30:0], 1'b1};
                acc_r_o = diff[15:0];
            end
            else
            begin
                acc_a_o = {acc_a_i[30:0], 1'b0};
                acc_r_o = trial[15:0];
            end
        end
    end

endmodule : muldiv_step

// [hdl/muldiv_unit.sv]
`timescale 1ns/1ns
// How it works
// - multiply a low half by b, product into a
// - divide a by b, quotient a, remainder separate
// - remainder is zero after a multiply
// - remainder cleared when a start is written
// - multiply start clears the a high half
// - reset clears all data and control registers
// - bit7 run, bit0 mode, bits6-1 zero
// - setting run starts the selected operation
// - run bit self-clears after results stored
// - multiply completes sixteen clocks after start
// - divide completes thirty-two clocks after start
// - completion interrupt pulses on the same edge that run clears
// - software clearing run aborts the operation
// - finish in clearing cycle still valid
// - a and remainder show intermediate values
// - control bit/byte writes, data byte/word access
module muldiv_unit
    import muldiv_pkg::*;
#(
    parameter int ADDR_W = 16                     // bus address width
)
(
    input  wire logic              mclk_i,        // peripheral clock
    input  wire logic              reset_i,       // synchronous reset
    input  wire logic [ADDR_W-1:0] addr_i,        // byte address
    input  wire logic              wr_i,          // write strobe
    input  wire logic              rd_i,          // read strobe
    input  wire logic [1:0]        be_i,          // byte lanes of the access
    input  wire logic              bit_wr_i,      // single-bit write
    input  wire logic [2:0]        bit_sel_i,     // bit number of a bit write
    input  wire logic [15:0]       wdata_i,       // write data
    output logic      [15:0]       rdata_o,       // registered read data
    output logic                   completion_irq_o // one-cycle done pulse
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {IDLE, RUN} state_t;

    state_t      state_q, state_d;                // engine state
    logic [31:0] operand_a_full_q, operand_a_full_d;  // a register
    logic [15:0] operand_b_q, operand_b_d;        // b register
    logic [15:0] remainder_result_q, remainder_result_d;
    logic        run_bit_q, run_bit_d;            // control bit 7
    logic        mode_select_bit_q, mode_select_bit_d; // control bit 0
    logic [5:0]  count_q, count_d;                // clocks since start
    logic [15:0] rdata_q, rdata_d;                // read data register
    logic        irq_q, irq_d;                    // completion pulse

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic        wr_ctrl, wr_al, wr_ah, wr_b;     // register selects
    logic [7:0]  ctrl_now;                        // current control byte
    logic [7:0]  ctrl_wr;                         // control byte after write
    logic        start;                           // run written 0 -> 1
    logic        stop;                            // run written to 0
    logic [31:0] step_a;                          // engine a output
    logic [15:0] step_r;                          // engine remainder output
    logic [5:0]  last_cnt;                        // final step count

    // full address compare: no aliases, so a stray write elsewhere is
    // simply dropped rather than landing in a live register
    assign wr_ctrl  = wr_i && (addr_i == ADDR_W'(CTRL_ADDR));
    assign wr_al    = wr_i && (addr_i == ADDR_W'(AL_ADDR));
    assign wr_ah    = wr_i && (addr_i == ADDR_W'(AH_ADDR));
    assign wr_b     = wr_i && (addr_i == ADDR_W'(B_ADDR));
    assign ctrl_now = {run_bit_q, 6'h00, mode_select_bit_q};
    assign last_cnt = mode_select_bit_q ? 6'(MUL_CYCLES - 1) : 6'(DIV_CYCLES - 1);

    // ------------------------------------------------------------------
    // control byte after a bit or byte write
    // ------------------------------------------------------------------
    // a bit write changes one bit and keeps the others, so software can
    // clear run alone without touching the mode bit
    always_comb
    begin
        ctrl_wr = ctrl_now;
        if (bit_wr_i)
        begin
            ctrl_wr[bit_sel_i] = wdata_i[0];
        end
        else if (be_i[0])
        begin
            ctrl_wr = wdata_i[7:0];
        end
        ctrl_wr[6:1] = 6'h00;
    end

    // only a 0 -> 1 change of run starts the engine; writing run = 1 again
    // while busy neither restarts nor disturbs the count
    assign start = wr_ctrl && ctrl_wr[RUN_BIT_POS] && !run_bit_q;
    assign stop  = wr_ctrl && !ctrl_wr[RUN_BIT_POS];

    // shared shift engine, one bit per clock; multiply adds and divide subtracts in separate adders,
    // which costs clocks but keeps each adder seventeen bits wide
    muldiv_step u_step
    (
        .mode_mul_i (mode_select_bit_q),
        .acc_a_i    (operand_a_full_q),
        .acc_r_i    (remainder_result_q),
        .divisor_i  (operand_b_q),
        .acc_a_o    (step_a),
        .acc_r_o    (step_r)
    );

    // ------------------------------------------------------------------
    // next state: registers, engine and run bit
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d            = state_q;
        operand_a_full_d   = operand_a_full_q;
        operand_b_d        = operand_b_q;
        remainder_result_d = remainder_result_q;
        run_bit_d          = run_bit_q;
        mode_select_bit_d  = mode_select_bit_q;
        count_d            = count_q;
        irq_d              = 1'b0;

        // writes to b land at any time, writes to a only while idle; a write
        // to b while running corrupts the result, which software is told not to do
        if (wr_al && be_i[0]) operand_a_full_d[7:0]   = wdata_i[7:0];
        if (wr_al && be_i[1]) operand_a_full_d[15:8]  = wdata_i[15:8];
        if (wr_ah && be_i[0]) operand_a_full_d[23:16] = wdata_i[7:0];
        if (wr_ah && be_i[1]) operand_a_full_d[31:24] = wdata_i[15:8];
        if (wr_b && be_i[0])  operand_b_d[7:0]        = wdata_i[7:0];
        if (wr_b && be_i[1])  operand_b_d[15:8]       = wdata_i[15:8];

        if (wr_ctrl)
        begin
            mode_select_bit_d = ctrl_wr[MODE_BIT_POS];
            run_bit_d         = ctrl_wr[RUN_BIT_POS];
        end

        // the engine works on the registers in place, so a and the
        // remainder carry partial values until the last step
        unique case (state_q)
            IDLE:
            begin
                // operands are used as they stand; nothing is copied aside
                if (start)
                begin
                    state_d            = RUN;
                    count_d            = 6'h00;
                    remainder_result_d = DATA_RESET;
                    if (ctrl_wr[MODE_BIT_POS])
                    begin
                        operand_a_full_d[31:16] = DATA_RESET;
                    end
                end
            end
            RUN:
            begin
                // intermediate values are visible in a and remainder
                operand_a_full_d   = step_a;
                remainder_result_d = step_r;
                count_d            = count_q + 6'h01;
                if (count_q == last_cnt)
                begin
                    // finishing wins over a clear in the same cycle, so
                    // the result stays good and the pulse still fires
                    state_d   = IDLE;
                    run_bit_d = 1'b0;
                    irq_d     = 1'b1;
                end
                else if (stop)
                begin
                    state_d = IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // read mux, registered so the output comes from a flip-flop
    // ------------------------------------------------------------------
    // reads while busy return partial values, as allowed; between reads
    // the data register holds, so the output only moves when a read is
    // taken
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_i)
        begin
            if (addr_i == ADDR_W'(CTRL_ADDR))     rdata_d = {8'h00, ctrl_now};
            else if (addr_i == ADDR_W'(AL_ADDR))  rdata_d = operand_a_full_q[15:0];
            else if (addr_i == ADDR_W'(AH_ADDR))  rdata_d = operand_a_full_q[31:16];
            else if (addr_i == ADDR_W'(B_ADDR))   rdata_d = operand_b_q;
            else if (addr_i == ADDR_W'(REM_ADDR)) rdata_d = remainder_result_q;
            else                                  rdata_d = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // synchronous reset clears every register; there is no asynchronous
    // path, so reset must be held across at least one clock edge
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state_q            <= IDLE;
            operand_a_full_q   <= {DATA_RESET, DATA_RESET};
            operand_b_q        <= DATA_RESET;
            remainder_result_q <= DATA_RESET;
            run_bit_q          <= CTRL_RESET[RUN_BIT_POS];
            mode_select_bit_q  <= CTRL_RESET[MODE_BIT_POS];
            count_q            <= 6'h00;
            rdata_q            <= 16'h0000;
            irq_q              <= 1'b0;
        end
        else
        begin
            state_q            <= state_d;
            operand_a_full_q   <= operand_a_full_d;
            operand_b_q        <= operand_b_d;
            remainder_result_q <= remainder_result_d;
            run_bit_q          <= run_bit_d;
            mode_select_bit_q  <= mode_select_bit_d;
            count_q            <= count_d;
            rdata_q            <= rdata_d;
            irq_q              <= irq_d;
        end
    end

    assign rdata_o          = rdata_q;
    assign completion_irq_o = irq_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // the operands are caught on the start edge and a flag remembers
    // whether the run went undisturbed; a clear that lands on the last
    // step still counts as undisturbed, since the result stands then
    logic [15:0] chk_a_lo, chk_b;                 // operands caught at start
    logic [31:0] chk_a_full;
    logic        chk_mul, chk_live;               // mode and undisturbed-run flag
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            chk_a_lo   <= 16'h0000;
            chk_b      <= 16'h0000;
            chk_a_full <= 32'h0000_0000;
            chk_mul    <= 1'b0;
            chk_live   <= 1'b0;
        end
        else if (state_q == IDLE && start)
        begin
            chk_a_lo   <= operand_a_full_d[15:0];
            chk_b      <= operand_b_d;
            chk_a_full <= operand_a_full_d;
            chk_mul    <= ctrl_wr[MODE_BIT_POS];
            chk_live   <= 1'b1;
        end
        else if (wr_al || wr_ah || wr_b || (wr_ctrl && state_q == RUN && count_q != last_cnt))
        begin
            chk_live   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // helper: edges since the last accepted start, saturating
    // ------------------------------------------------------------------
    // a free count kept apart from the engine counter, so the timing
    // checks below judge the engine instead of repeating it
    logic [5:0]  chk_since;                       // edges since start
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            chk_since <= 6'h3f;                   // parked: no start seen
        end
        else if (state_q == IDLE && start)
        begin
            chk_since <= 6'h01;                   // the start edge itself counts as one
        end
        else if (chk_since != 6'h3f)
        begin
            chk_since <= chk_since + 6'h01;       // holds at the top
        end
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    // results are judged only for runs that nobody disturbed; a write
    // during a run leaves the outcome undefined, so nothing is claimed
    mul_result_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        irq_q && chk_mul && chk_live |->
            operand_a_full_q == chk_a_lo * chk_b && remainder_result_q == 16'h0000)
        else $error("multiply product wrong");
    div_result_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        irq_q && !chk_mul && chk_live && chk_b != 16'h0000 |->
            operand_a_full_q == chk_a_full / chk_b
            && remainder_result_q == 16'(chk_a_full % chk_b))
        else $error("divide result wrong");
    rem_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_q == IDLE && start |=> remainder_result_q == 16'h0000)
        else $error("remainder not cleared at start");
    high_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_q == IDLE && start && ctrl_wr[0] && !wr_ah |=> operand_a_full_q[31:16] == 16'h0000)
        else $error("high half not cleared on multiply start");
    mul_time_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        chk_live && chk_mul && chk_since == 6'(MUL_CYCLES + 1) |-> irq_q && !run_bit_q)
        else $error("multiply not done after sixteen clocks");
    div_time_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        chk_live && !chk_mul && chk_since == 6'(DIV_CYCLES + 1) |-> irq_q && !run_bit_q)
        else $error("divide not done after thirty-two clocks");

    irq_time_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        irq_q && chk_live |->
            chk_since == (chk_mul ? 6'(MUL_CYCLES + 1) : 6'(DIV_CYCLES + 1)))
        else $error("completion pulse at the wrong time");
    run_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        irq_q |-> !run_bit_q && state_q == IDLE)
        else $error("run bit set at completion");
    abort_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_q == RUN && stop && count_q != last_cnt |=> state_q == IDLE && !irq_q)
        else $error("clearing run did not abort");
    zero_bits_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        rd_i && addr_i == ADDR_W'(CTRL_ADDR) |=>
            rdata_q[15:1] == {8'h00, $past(run_bit_q), 6'h00})
        else $error("control reserved bits not zero");

    reset_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(reset_i) |-> operand_a_full_q == 32'h0000_0000 && operand_b_q == 16'h0000
            && remainder_result_q == 16'h0000 && !run_bit_q && !mode_select_bit_q)
        else $error("registers not cleared by reset");
    mode_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !wr_ctrl |=> $stable(mode_select_bit_q))
        else $error("mode bit moved without a control write");

endmodule : muldiv_unit

// [verification/test_muldiv_unit.sv]
`timescale 1ns/1ns
module test_muldiv_unit;
    import muldiv_pkg::*;

    // ------------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------------
    logic        mclk_i    = 1'b0;   // 10 MHz peripheral clock
    logic        reset_i   = 1'b1;   // synchronous reset, held at start
    logic [15:0] addr_i    = 16'h0000;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [1:0]  be_i      = 2'h0;
    logic        bit_wr_i  = 1'b0;
    logic [2:0]  bit_sel_i = 3'h0;
    logic [15:0] wdata_i   = 16'h0000;
    logic [15:0] rdata_o;
    logic        completion_irq_o;
    int          err_count  = 0;     // mismatches seen
    int          num_checks = 0;     // comparisons made
    int          cycles     = 0;     // watchdog count

    muldiv_unit dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .be_i(be_i), .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .completion_irq_o(completion_irq_o));

    // clock: half period of 50 ns
    always #50 mclk_i = ~mclk_i;

    // ------------------------------------------------------------------
    // closing report and watchdog
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // a hung handshake must not stall the run; the whole sequence needs ~340 cycles
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // bus helpers: drive on the falling edge, taken on the rising edge
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // each transfer first lets one clock edge pass idle, so a strobe that
    // the last call lowered is never raised again in the same time step
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        @(negedge mclk_i);
        addr_i  = a;
        wdata_i = d;
        be_i    = be;
        wr_i    = 1'b1;
        @(posedge mclk_i);
        @(negedge mclk_i);
        wr_i    = 1'b0;
    endtask : wr_reg

    // single-bit write to the control register
    task automatic bit_wr(input logic [2:0] pos, input logic v);
        @(negedge mclk_i);
        addr_i    = CTRL_ADDR;
        wdata_i   = {15'h0000, v};
        bit_sel_i = pos;
        bit_wr_i  = 1'b1;
        wr_i      = 1'b1;
        @(posedge mclk_i);
        @(negedge mclk_i);
        wr_i      = 1'b0;
        bit_wr_i  = 1'b0;
    endtask : bit_wr

    // read data is registered, so it is settled by the following falling edge
    task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge mclk_i);
        addr_i = a;
        rd_i   = 1'b1;
        @(posedge mclk_i);
        @(negedge mclk_i);
        rd_i   = 1'b0;
        check({16'h0000, rdata_o}, {16'h0000, exp});
    endtask : chk_rd

    // count edges from the start edge to the completion pulse, then see it drop
    task automatic wait_done(input int n_exp);
        int n;
        n = 0;
        while (completion_irq_o !== 1'b1 && n < 100)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check(n, n_exp);
        @(posedge mclk_i);
        #1;
        check(completion_irq_o, 1'b0);
        @(negedge mclk_i);
    endtask : wait_done

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_rd(CTRL_ADDR, CTRL_RESET);
        chk_rd(AL_ADDR, DATA_RESET);
        chk_rd(AH_ADDR, DATA_RESET);
        chk_rd(B_ADDR, DATA_RESET);
        chk_rd(REM_ADDR, DATA_RESET);
    endtask : t_reset

    // fixed-zero bits, bit writes and byte lanes, unmapped place
    task automatic t_access();
        wr_reg(CTRL_ADDR, 16'h007e, 2'h1);
        chk_rd(CTRL_ADDR, 16'h0000);
        bit_wr(3'h0, 1'b1);
        chk_rd(CTRL_ADDR, 16'h0001);
        bit_wr(3'h0, 1'b0);
        chk_rd(CTRL_ADDR, 16'h0000);
        wr_reg(B_ADDR, 16'h1234, 2'h3);
        wr_reg(B_ADDR, 16'hab99, 2'h2);
        chk_rd(B_ADDR, 16'hab34);
        wr_reg(AL_ADDR, 16'h55cd, 2'h1);
        chk_rd(AL_ADDR, 16'h00cd);
        chk_rd(16'hff70, 16'h0000);
    endtask : t_access

    // junk in the high half must be cleared by the multiply start
    // operands are left untouched from start to completion
    task automatic t_mul(input logic [15:0] a, input logic [15:0] b, input logic [15:0] junk);
        logic [31:0] p;
        p = {16'h0000, a} * {16'h0000, b};
        wr_reg(AH_ADDR, junk, 2'h3);
        wr_reg(AL_ADDR, a, 2'h3);
        wr_reg(B_ADDR, b, 2'h3);
        wr_reg(CTRL_ADDR, 16'h0081, 2'h1);
        wait_done(MUL_CYCLES);
        chk_rd(CTRL_ADDR, 16'h0001);
        chk_rd(AL_ADDR, p[15:0]);
        chk_rd(AH_ADDR, p[31:16]);
        chk_rd(REM_ADDR, 16'h0000);
    endtask : t_mul

    task automatic t_div(input logic [31:0] dd, input logic [15:0] dv);
        logic [31:0] q;
        logic [31:0] r;
        q = dd / {16'h0000, dv};
        r = dd % {16'h0000, dv};
        wr_reg(AL_ADDR, dd[15:0], 2'h3);
        wr_reg(AH_ADDR, dd[31:16], 2'h3);
        wr_reg(B_ADDR, dv, 2'h3);
        wr_reg(CTRL_ADDR, 16'h0080, 2'h1);
        wait_done(DIV_CYCLES);
        chk_rd(CTRL_ADDR, 16'h0000);
        chk_rd(AL_ADDR, q[15:0]);
        chk_rd(AH_ADDR, q[31:16]);
        chk_rd(REM_ADDR, r[15:0]);
    endtask : t_div

    // clearing run mid-operation stops it: no completion pulse follows
    task automatic t_abort();
        int seen;
        seen = 0;
        wr_reg(AL_ADDR, 16'h1111, 2'h3);
        wr_reg(AH_ADDR, 16'h2222, 2'h3);
        wr_reg(B_ADDR, 16'h0007, 2'h3);
        wr_reg(CTRL_ADDR, 16'h0080, 2'h1);
        repeat (5) @(negedge mclk_i);
        bit_wr(3'h7, 1'b0);
        repeat (40)
        begin
            @(posedge mclk_i);
            #1;
            if (completion_irq_o === 1'b1)
                seen++;
        end
        @(negedge mclk_i);
        check(seen, 0);
        chk_rd(CTRL_ADDR, 16'h0000);
    endtask : t_abort

    // software clear taken on the very edge that finishes: finish wins
    task automatic t_race();
        wr_reg(AL_ADDR, 16'h00da, 2'h3);
        wr_reg(AH_ADDR, 16'h0000, 2'h3);
        wr_reg(B_ADDR, 16'h0093, 2'h3);
        wr_reg(CTRL_ADDR, 16'h0081, 2'h1);
        // bit_wr idles one edge first, so its write lands on the sixteenth step
        repeat (MUL_CYCLES - 2) @(negedge mclk_i);
        bit_wr(3'h7, 1'b0);
        check(completion_irq_o, 1'b1);
        chk_rd(AL_ADDR, 16'h7d2e);
        chk_rd(AH_ADDR, 16'h0000);
    endtask : t_race

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_i = 1'b0;
        t_reset();
        t_access();
        t_div(32'hdcba2586, 16'h0018);
        t_mul(16'h00da, 16'h0093, 16'hffff);
        t_mul(16'hffff, 16'hffff, 16'h1234);
        t_div(32'hffffffff, 16'hffff);
        t_div(32'h00000005, 16'h0009);
        t_abort();
        t_race();
        stop_test();
    end

endmodule : test_muldiv_unit
